// File: design/lpwc_defs.svh
`ifndef LPWC_DEFS_SVH
`define LPWC_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define LPWC_CLK_HZ 50000000
`define LPWC_TICK_SECONDS 1
`define LPWC_TICK_CYCLES (`LPWC_CLK_HZ * `LPWC_TICK_SECONDS)

// ----------------------------------------
// Variant codes and delay width
// ----------------------------------------
`define LPWC_SEL_IDLE 2'h0
`define LPWC_SEL_SLEEP 2'h1
`define LPWC_SEL_STOP 2'h2
`define LPWC_DELAY_WIDTH 8

`endif

// File: design/lpwc_pkg.sv
package lpwc_pkg;

   // ----------------------------------------
   // Power modes
   // ----------------------------------------
   typedef enum logic [1:0] {
      LPWC_NORMAL,
      LPWC_IDLE,
      LPWC_SLEEP,
      LPWC_STOP
   } lpwc_mode_type;

   // ----------------------------------------
   // Status carried out of the block
   // ----------------------------------------
   typedef struct packed {
      logic low_power;
      logic idle;
      logic sleep;
      logic stop;
   } lpwc_status_type;

endpackage

// File: design/lpwc_ctrl.sv
// Notes on behaviour
// RULE_01 - Programmable whole-second inactivity delay held
// RULE_02 - Any host or line activity restarts count
// RULE_03 - Zero delay never enters low power
// RULE_04 - Expiry enters idle, sleep or stop
// RULE_05 - Ring or host transmit activity wakes
// RULE_06 - Idle: first host byte processed normally
// RULE_07 - Sleep/stop: waking byte is discarded
// RULE_08 - Host resends command lost at wake
// RULE_09 - One-second tick advances count, compared
`include "lpwc_defs.svh"

module lpwc_ctrl
   import lpwc_pkg::*;
#(
   parameter int TICK_CYCLES = `LPWC_TICK_CYCLES,
   parameter int DELAY_WIDTH = `LPWC_DELAY_WIDTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Configuration
   input wire logic [DELAY_WIDTH-1:0] lowpower_delay_setting,
   input wire logic [1:0] lowpower_variant_select,
   // Activity sources
   input wire logic host_transmit_line,
   input wire logic host_byte_valid,
   input wire logic line_activity,
   input wire logic ring_detect,
   // Outputs
   output lpwc_mode_type mode,
   output lpwc_status_type status,
   output logic host_byte_accept,
   output logic wake_pulse
);

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [1:0] txd_sync_r, line_sync_r, ring_sync_r;
   logic txd_prev_r;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         txd_sync_r <= 2'h3;
         line_sync_r <= 2'h0;
         ring_sync_r <= 2'h0;
         txd_prev_r <= 1'b1;
      end else begin
         txd_sync_r <= {txd_sync_r[0], host_transmit_line};
         line_sync_r <= {line_sync_r[0], line_activity};
         ring_sync_r <= {ring_sync_r[0], ring_detect};
         txd_prev_r <= txd_sync_r[1];
      end
   end

   logic txd_act, line_act, ring_act;
   always_comb begin
      txd_act = txd_prev_r ^ txd_sync_r[1];
      line_act = line_sync_r[1];
      ring_act = ring_sync_r[1];
   end

   // ----------------------------------------
   // Second tick divider
   // ----------------------------------------
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   logic [TW-1:0] div_r, div_nxt;
   logic tick;
   logic [DELAY_WIDTH-1:0] sec_r, sec_nxt;
   lpwc_mode_type mode_r, mode_nxt;
   logic accept_r, accept_nxt, wake_r, wake_nxt;
   logic drop_r, drop_nxt;
   logic activity;

   always_comb begin
      activity = txd_act | line_act | host_byte_valid;
      tick = (div_r == TICK_LAST);
      div_nxt = tick ? '0 : div_r + TW'(1); // RULE_09
      if (activity || mode_r != LPWC_NORMAL) begin
         div_nxt = '0; // RULE_02
      end
   end

   // ----------------------------------------
   // Inactivity count and mode machine
   // ----------------------------------------
   always_comb begin
      sec_nxt = sec_r;
      mode_nxt = mode_r;
      accept_nxt = host_byte_valid;
      wake_nxt = 1'b0;
      drop_nxt = drop_r;
      unique case (mode_r)
         LPWC_NORMAL: begin
            accept_nxt = host_byte_valid & ~drop_r; // RULE_07
            if (host_byte_valid) begin
               drop_nxt = 1'b0;
            end
            if (activity) begin
               sec_nxt = '0; // RULE_02
            end else if (lowpower_delay_setting == '0) begin
               sec_nxt = '0; // RULE_03
            end else if (tick) begin
               sec_nxt = sec_r + DELAY_WIDTH'(1); // RULE_09
               if (sec_nxt >= lowpower_delay_setting) begin // RULE_01
                  sec_nxt = '0;
                  if (lowpower_variant_select == `LPWC_SEL_SLEEP) begin // RULE_04
                     mode_nxt = LPWC_SLEEP;
                  end else if (lowpower_variant_select == `LPWC_SEL_STOP) begin
                     mode_nxt = LPWC_STOP;
                  end else begin
                     mode_nxt = LPWC_IDLE;
                  end
               end
            end
         end
         LPWC_IDLE: begin
            if (ring_act || txd_act || host_byte_valid) begin
               mode_nxt = LPWC_NORMAL; // RULE_05
               wake_nxt = 1'b1;
            end
            accept_nxt = host_byte_valid; // RULE_06
            drop_nxt = 1'b0; // RULE_06
         end
         LPWC_SLEEP, LPWC_STOP: begin
            if (ring_act || txd_act || host_byte_valid) begin
               mode_nxt = LPWC_NORMAL; // RULE_05
               wake_nxt = 1'b1;
               drop_nxt = txd_act & ~host_byte_valid; // RULE_07
            end
            accept_nxt = 1'b0; // RULE_07
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         div_r <= '0;
         sec_r <= '0;
         mode_r <= LPWC_NORMAL;
         accept_r <= 1'b0;
         wake_r <= 1'b0;
         drop_r <= 1'b0;
      end else begin
         div_r <= div_nxt;
         sec_r <= sec_nxt;
         mode_r <= mode_nxt;
         accept_r <= accept_nxt;
         wake_r <= wake_nxt;
         drop_r <= drop_nxt;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   lpwc_status_type status_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         status_r <= '0;
      end else begin
         status_r.low_power <= (mode_nxt != LPWC_NORMAL);
         status_r.idle <= (mode_nxt == LPWC_IDLE);
         status_r.sleep <= (mode_nxt == LPWC_SLEEP);
         status_r.stop <= (mode_nxt == LPWC_STOP);
      end
   end

   always_comb begin
      mode = mode_r;
      status = status_r;
      host_byte_accept = accept_r;
      wake_pulse = wake_r;
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_zero_delay;
      @(posedge clock) disable iff (rst)
      (lowpower_delay_setting == '0 && mode_r == LPWC_NORMAL) |=> mode_r == LPWC_NORMAL;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("entered low power with zero delay"); // RULE_03

   property p_restart;
      @(posedge clock) disable iff (rst)
      (mode_r == LPWC_NORMAL && activity) |=> sec_r == '0 && div_r == '0;
   endproperty
   a_restart: assert property (p_restart) else $error("activity did not restart count"); // RULE_02

   property p_enter;
      @(posedge clock) disable iff (rst)
      (mode_r == LPWC_NORMAL && !activity && tick && lowpower_delay_setting != '0
       && sec_r + DELAY_WIDTH'(1) >= lowpower_delay_setting
       && lowpower_variant_select == `LPWC_SEL_SLEEP) |=> mode_r == LPWC_SLEEP;
   endproperty
   a_enter: assert property (p_enter) else $error("sleep not entered at expiry"); // RULE_04

   property p_no_early;
      @(posedge clock) disable iff (rst)
      (mode_r == LPWC_NORMAL && !tick) |=> mode_r == LPWC_NORMAL;
   endproperty
   a_no_early: assert property (p_no_early) else $error("low power entered off a tick"); // RULE_01

   property p_wake;
      @(posedge clock) disable iff (rst)
      (mode_r != LPWC_NORMAL && ring_act) |=> mode_r == LPWC_NORMAL && wake_pulse;
   endproperty
   a_wake: assert property (p_wake) else $error("ring did not wake"); // RULE_05

   property p_idle_accept;
      @(posedge clock) disable iff (rst)
      (host_byte_valid && (mode_r == LPWC_IDLE || (mode_r == LPWC_NORMAL && !drop_r)))
      |=> host_byte_accept;
   endproperty
   a_idle_accept: assert property (p_idle_accept) else $error("idle byte dropped"); // RULE_06

   property p_sleep_drop;
      @(posedge clock) disable iff (rst)
      (host_byte_valid && (mode_r inside {LPWC_SLEEP, LPWC_STOP} || drop_r))
      |=> !host_byte_accept;
   endproperty
   a_sleep_drop: assert property (p_sleep_drop) else $error("waking byte accepted"); // RULE_07

   property p_drop_arm;
      @(posedge clock) disable iff (rst)
      (mode_r inside {LPWC_SLEEP, LPWC_STOP} && txd_act && !host_byte_valid) |=> drop_r;
   endproperty
   a_drop_arm: assert property (p_drop_arm) else $error("discard not armed"); // RULE_07

   property p_tick_period;
      @(posedge clock) disable iff (rst)
      tick |=> div_r == '0;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("divider not restarted"); // RULE_09

   property p_status;
      @(posedge clock) disable iff (rst)
      ##1 status.low_power == (mode_r != LPWC_NORMAL);
   endproperty
   a_status: assert property (p_status) else $error("status disagrees with mode");

   c_idle: cover property (@(posedge clock) disable iff (rst) mode_r == LPWC_IDLE);
   c_sleep: cover property (@(posedge clock) disable iff (rst) mode_r == LPWC_SLEEP);
   c_stop_wake: cover property (@(posedge clock) disable iff (rst)
      mode_r == LPWC_STOP ##1 mode_r == LPWC_NORMAL);
   c_byte_drop: cover property (@(posedge clock) disable iff (rst) drop_r && host_byte_valid);

endmodule

// File: tb/lpwc_host_model.sv
module lpwc_host_model (
   // Clock
   input wire logic clock,
   // Requests from the bench
   input wire logic snd_byte,
   input wire logic snd_ring,
   input wire logic snd_line,
   // Far side signals
   output logic host_transmit_line,
   output logic host_byte_valid,
   output logic line_activity,
   output logic ring_detect
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Serial frame: start, 8'h41, stop
   // ----------------------------------------
   logic [9:0] frame = 10'h282;
   int bcnt = 0;
   int rcnt = 0;
   int lcnt = 0;
   initial begin
      host_transmit_line = 1'b1;
      host_byte_valid = 1'b0;
      line_activity = 1'b0;
      ring_detect = 1'b0;
   end
   always @(posedge clock) begin
      host_byte_valid <= (bcnt == 1);
      host_transmit_line <= (bcnt > 0) ? frame[10-bcnt] : 1'b1;
      bcnt <= snd_byte ? 10 : ((bcnt > 0) ? bcnt - 1 : 0);
      ring_detect <= (rcnt > 0);
      rcnt <= snd_ring ? 6 : ((rcnt > 0) ? rcnt - 1 : 0);
      line_activity <= (lcnt > 0);
      lcnt <= snd_line ? 4 : ((lcnt > 0) ? lcnt - 1 : 0);
   end
endmodule

// File: tb/tb_top.sv
module tb_top import lpwc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 10;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [7:0] dly;
   logic [1:0] sel;
   logic snd_byte, snd_ring, snd_line;
   logic host_transmit_line, host_byte_valid, line_activity, ring_detect;
   lpwc_mode_type mode, em;
   lpwc_status_type status;
   logic host_byte_accept, wake_pulse;
   logic [16:0] lfsr = 17'h15435;
   int err_total = 0;
   int n_checks = 0;
   int n_acc = 0;
   int n_wake = 0;
   int n, a0, w0;
   int acc_q[$];
   logic vld_d = 1'b0;
   // ----------------------------------------
   // Clock, design and far side
   // ----------------------------------------
   initial forever #10 clock = ~clock;
   lpwc_ctrl #(.TICK_CYCLES(TK), .DELAY_WIDTH(8)) i_dut (.clock(clock), .rst(rst),
      .lowpower_delay_setting(dly), .lowpower_variant_select(sel),
      .host_transmit_line(host_transmit_line), .host_byte_valid(host_byte_valid),
      .line_activity(line_activity), .ring_detect(ring_detect), .mode(mode),
      .status(status), .host_byte_accept(host_byte_accept), .wake_pulse(wake_pulse));
   lpwc_host_model i_far (.clock(clock), .snd_byte(snd_byte), .snd_ring(snd_ring),
      .snd_line(snd_line), .host_transmit_line(host_transmit_line),
      .host_byte_valid(host_byte_valid), .line_activity(line_activity),
      .ring_detect(ring_detect));
   always @(posedge clock) begin
      if (host_byte_accept === 1'b1) n_acc++;
      if (wake_pulse === 1'b1) n_wake++;
      if (vld_d === 1'b1 && acc_q.size() > 0) begin
         chk("accept_model", 4'(host_byte_accept), 4'(acc_q.pop_front()));
      end
      vld_d <= host_byte_valid;
   end
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic req(input int k);
      @(posedge clock);
      snd_byte <= (k == 1);
      snd_ring <= (k == 2);
      snd_line <= (k == 3);
      @(posedge clock);
      {snd_byte, snd_ring, snd_line} <= 3'h0;
   endtask
   function automatic logic [16:0] lfsr_next(input logic [16:0] v);
      return {v[15:0], v[16] ^ v[13]};
   endfunction
   function automatic logic [3:0] exp_st(input lpwc_mode_type m);
      return {m != LPWC_NORMAL, m == LPWC_IDLE, m == LPWC_SLEEP, m == LPWC_STOP};
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      dly = 8'h00;
      sel = 2'h0;
      {snd_byte, snd_ring, snd_line} = 3'h0;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      cyc(40 * TK);
      chk("mode_zero_delay", mode, LPWC_NORMAL);
      for (int s = 0; s < 4; s++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge clock);
         dly <= {6'h00, lfsr[1:0]} + 8'h01;
         sel <= s[1:0];
         em = (s == 1) ? LPWC_SLEEP : (s == 2) ? LPWC_STOP : LPWC_IDLE;
         req(3);
         n = int'(dly) * TK;
         cyc(n);
         chk("mode_before_expiry", mode, LPWC_NORMAL);
         req(3);
         cyc(n);
         chk("mode_after_restart", mode, LPWC_NORMAL);
         cyc(12);
         chk("mode_expired", mode, em);
         chk("status_expired", status, exp_st(em));
         a0 = n_acc;
         w0 = n_wake;
         acc_q.push_back((em == LPWC_IDLE) ? 1 : 0);
         req(1);
         cyc(14);
         chk("mode_byte_wake", mode, LPWC_NORMAL);
         chk("status_byte_wake", status, 4'h0);
         chk("wake_count", 4'(n_wake - w0), 4'h1);
         chk("accept_waking", 4'(n_acc - a0), (em == LPWC_IDLE) ? 4'h1 : 4'h0);
         acc_q.push_back(1);
         req(1);
         cyc(14);
         chk("accept_resend", 4'(n_acc - a0), (em == LPWC_IDLE) ? 4'h2 : 4'h1);
      end
      @(posedge clock);
      sel <= 2'h1;
      cyc(n + 12);
      chk("mode_before_ring", mode, LPWC_SLEEP);
      req(2);
      cyc(12);
      chk("mode_ring_wake", mode, LPWC_NORMAL);
      chk("status_ring_wake", status, 4'h0);
      acc_q.push_back(1);
      req(1);
      cyc(14);
      chk("model_drained", 4'(acc_q.size()), 4'h0);
      complete_run();
   end
   initial begin
      cyc(20000);
      err_total++;
      complete_run();
   end
endmodule
